/* File: motion_profile_model.sv */
module motion_profile_model #(parameter int MOVE = 40) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire logic i_decel,
   input wire logic [15:0] i_time,
   output logic o_done,
   output logic o_stopped
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   logic mv, dc;
   // Standstill is a level so a paused step still reads as stopped
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         {cnt, mv, dc, o_done, o_stopped} <= '0;
      end else begin
         o_done <= 1'h0;
         if (i_decel || i_start) begin
            {mv, dc, o_stopped} <= {i_start && !i_decel, i_decel, 1'h0};
            cnt <= i_decel ? ((i_time == 16'h0) ? 0 : 8) : MOVE;
         end else if (cnt > 0) cnt <= cnt - 1;
         else if (mv) {mv, o_done} <= 2'h1;
         else if (dc) {dc, o_stopped} <= 2'h1;
      end
   end
endmodule // motion_profile_model

/* File: motion_stop_control.v */
`include "motion_stop_control_regs.vh"
module motion_stop_control (
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_multifunction_input_a,
   input wire i_multifunction_input_b,
   input wire i_start_strobe_input,
   input wire [1:0] i_input_a_function_select,
   input wire [1:0] i_input_b_function_select,
   input wire i_input_a_logic_select,
   input wire i_input_b_logic_select,
   input wire i_shared_output_select,
   input wire [`DECEL_W-1:0] i_emergency_decel_time,
   input wire [`DECEL_W-1:0] i_mode_decel_time,
   input wire [1:0] i_start_kind,
   input wire [`POINT_W-1:0] i_point_select_inputs,
   input wire i_motion_done,
   input wire i_motion_stopped,
   output reg o_motion_start,
   output reg o_motion_decel,
   output reg [`DECEL_W-1:0] o_decel_time,
   output reg [`POINT_W-1:0] o_target_point,
   output reg o_in_operation,
   output reg o_shared_output,
   output reg [`POINT_W-1:0] o_current_point_outputs
);
   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   reg [2:0] sync_1;
   reg [2:0] sync_2;
   reg strobe_prev;
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync_1 <= 3'h0;
         sync_2 <= 3'h0;
         strobe_prev <= 1'b0;
      end else begin
         sync_1 <= {i_start_strobe_input, i_multifunction_input_b, i_multifunction_input_a};
         sync_2 <= sync_1;
         strobe_prev <= sync_2[2];
      end
   end

   // ----------------------------------------
   // Input decode
   // ----------------------------------------
   wire act_a = sync_2[0] ^ i_input_a_logic_select;
   wire act_b = sync_2[1] ^ i_input_b_logic_select;
   wire emerg = (act_a && i_input_a_function_select == `FUNC_EMERGENCY) ||
                (act_b && i_input_b_function_select == `FUNC_EMERGENCY);
   wire dstop = (act_a && i_input_a_function_select == `FUNC_DECEL_STOP) ||
                (act_b && i_input_b_function_select == `FUNC_DECEL_STOP);
   wire tstop = (act_a && i_input_a_function_select == `FUNC_TEMP_STOP) ||
                (act_b && i_input_b_function_select == `FUNC_TEMP_STOP);
   wire strobe_rise = sync_2[2] && !strobe_prev;

   // ----------------------------------------
   // Control state machine
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RUN = 3'h1;
   localparam [2:0] ST_STOPPING = 3'h2;
   localparam [2:0] ST_PAUSING = 3'h3;
   localparam [2:0] ST_PAUSED = 3'h4;

   reg [2:0] state;
   reg [1:0] run_kind;
   reg emerg_phase;
   reg held_valid;
   reg [`POINT_W-1:0] held_point;
   reg [`POINT_W-1:0] run_point;

   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= ST_IDLE;
         run_kind <= `OP_STEP;
         emerg_phase <= 1'b0;
         held_valid <= 1'b0;
         held_point <= {`POINT_W{1'b0}};
         run_point <= {`POINT_W{1'b0}};
         o_motion_start <= 1'b0;
         o_motion_decel <= 1'b0;
         o_decel_time <= {`DECEL_W{1'b0}};
         o_target_point <= {`POINT_W{1'b0}};
         o_in_operation <= 1'b1;
         o_current_point_outputs <= {`POINT_W{1'b0}};
      end else begin
         o_motion_start <= 1'b0;
         o_motion_decel <= 1'b0;
         // Stops resolved before any start is looked at
         if ((emerg || dstop) && state != ST_IDLE && !(state == ST_STOPPING && emerg_phase)) begin
            if (emerg) begin
               o_motion_decel <= 1'b1;
               // Already braking: no second ramp
               if (state == ST_STOPPING || state == ST_PAUSING)
                  o_decel_time <= {`DECEL_W{1'b0}};
               else
                  o_decel_time <= i_emergency_decel_time;
               emerg_phase <= 1'b1;
               state <= ST_STOPPING;
            end else if (state == ST_RUN || state == ST_PAUSED) begin
               o_motion_decel <= (state == ST_RUN);
               // Paused motor is already still: time only issued with a ramp
               if (state == ST_RUN)
                  o_decel_time <= i_mode_decel_time;
               emerg_phase <= 1'b0;
               state <= ST_STOPPING;
            end
            held_valid <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  o_in_operation <= 1'b1;
                  // Starts dropped while an emergency or deceleration stop input is active
                  if (emerg || dstop) begin
                     // A held step must not outlive a hard stop
                     held_valid <= 1'b0;
                  end else if (strobe_rise) begin
                     if (tstop) begin
                        if (i_start_kind == `OP_STEP) begin
                           held_valid <= 1'b1;
                           held_point <= i_point_select_inputs;
                        end
                     end else begin
                        o_motion_start <= 1'b1;
                        o_target_point <= i_point_select_inputs;
                        run_point <= i_point_select_inputs;
                        run_kind <= i_start_kind;
                        o_in_operation <= 1'b0;
                        state <= ST_RUN;
                     end
                  end else if (held_valid && !tstop) begin
                     o_motion_start <= 1'b1;
                     o_target_point <= held_point;
                     run_point <= held_point;
                     run_kind <= `OP_STEP;
                     held_valid <= 1'b0;
                     o_in_operation <= 1'b0;
                     state <= ST_RUN;
                  end
               end
               ST_RUN: begin
                  if (tstop) begin
                     o_motion_decel <= 1'b1;
                     o_decel_time <= i_mode_decel_time;
                     emerg_phase <= 1'b0;
                     // Jog and homing cannot resume
                     state <= (run_kind == `OP_STEP) ? ST_PAUSING : ST_STOPPING;
                  end else if (i_motion_done) begin
                     o_current_point_outputs <= run_point;
                     o_in_operation <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               ST_STOPPING: begin
                  if (i_motion_stopped) begin
                     o_in_operation <= 1'b1;
                     emerg_phase <= 1'b0;
                     // Point outputs untouched: keep pre-decel value
                     state <= ST_IDLE;
                  end
               end
               ST_PAUSING: begin
                  // Full stop first even if released early
                  if (i_motion_stopped)
                     state <= ST_PAUSED;
               end
               ST_PAUSED: begin
                  if (!tstop) begin
                     o_motion_start <= 1'b1;
                     o_target_point <= run_point;
                     state <= ST_RUN;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Shared output
   // ----------------------------------------
   wire decelerating = (state == ST_STOPPING) || (state == ST_PAUSING);
   wire done = (state == ST_IDLE) || (state == ST_PAUSED);
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n)
         o_shared_output <= 1'b0;
      else
         o_shared_output <= (i_shared_output_select == `SHARED_SEL_DECEL) ? decelerating : done;
   end
endmodule // motion_stop_control

/* File: motion_stop_control_monitor.sv */
module motion_stop_control_monitor (
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_multifunction_input_a,
   input wire [1:0] i_input_a_function_select,
   input wire i_input_a_logic_select,
   input wire i_motion_done,
   input wire i_motion_stopped,
   input wire o_motion_start,
   input wire o_motion_decel,
   input wire [15:0] o_decel_time,
   input wire [5:0] o_target_point,
   input wire o_in_operation,
   input wire [5:0] o_current_point_outputs
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // Five samples so the two-stage synchroniser has surely caught up
   wire emg = (i_multifunction_input_a ^ i_input_a_logic_select) && i_input_a_function_select == 2'h1;
   property p_stop_blocks_start; emg [*5] |-> !o_motion_start; endproperty
   a_stop_blocks_start: assert property (p_stop_blocks_start) else $error("start during stop");
   property p_stop_first; o_motion_decel |-> !o_motion_start; endproperty
   a_stop_first: assert property (p_stop_first) else $error("start beside decel");
   property p_start_pulse; o_motion_start |=> !o_motion_start; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
   property p_time_moves; !$stable(o_decel_time) |-> o_motion_decel; endproperty
   a_time_moves: assert property (p_time_moves) else $error("decel time changed alone");
   property p_target_moves; !$stable(o_target_point) |-> o_motion_start; endproperty
   a_target_moves: assert property (p_target_moves) else $error("target changed alone");
   property p_busy_ends; $rose(o_in_operation) |-> $past(i_motion_done) || $past(i_motion_stopped); endproperty
   a_busy_ends: assert property (p_busy_ends) else $error("idle without standstill");
   property p_busy_starts; $fell(o_in_operation) |-> o_motion_start; endproperty
   a_busy_starts: assert property (p_busy_starts) else $error("busy without start");
   property p_point_hold; !$stable(o_current_point_outputs) |-> $past(i_motion_done); endproperty
   a_point_hold: assert property (p_point_hold) else $error("point moved without completion");
endmodule // motion_stop_control_monitor
bind motion_stop_control motion_stop_control_monitor i_monitor (.i_clk_sys, .i_reset_n,
   .i_multifunction_input_a, .i_input_a_function_select, .i_input_a_logic_select, .i_motion_done,
   .i_motion_stopped, .o_motion_start, .o_motion_decel, .o_decel_time, .o_target_point, .o_in_operation,
   .o_current_point_outputs);

/* File: motion_stop_control_regs.vh */
`ifndef MOTION_STOP_CONTROL_REGS_VH
`define MOTION_STOP_CONTROL_REGS_VH
// ----------------------------------------
// Function select codes (2 bits)
// ----------------------------------------
`define FUNC_NONE 2'h0
`define FUNC_EMERGENCY 2'h1
`define FUNC_DECEL_STOP 2'h2
`define FUNC_TEMP_STOP 2'h3
// ----------------------------------------
// Operation kinds (2 bits)
// ----------------------------------------
`define OP_STEP 2'h0
`define OP_JOG 2'h1
`define OP_HOMING 2'h2
// ----------------------------------------
// Widths
// ----------------------------------------
`define POINT_W 6
`define DECEL_W 16
// ----------------------------------------
// Shared output select
// ----------------------------------------
`define SHARED_SEL_DONE 1'b0
`define SHARED_SEL_DECEL 1'b1
`endif

/* File: motion_stop_control_tb.sv */
`include "motion_stop_control_regs.vh"
module motion_stop_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, a, b, stb = 0, la, lb, sel, done, stopped, start, decel, inop, sh;
   logic [1:0] fa = `FUNC_EMERGENCY, fb = `FUNC_DECEL_STOP, kind = 0;
   logic [15:0] et = 16'h5, mt = 16'h3, dt;
   logic [5:0] pt = 0, cur = 0, tp, cp;
   logic [31:0] r = 32'h8494;
   logic [5:0] q[$];
   int num_errors = 0, total_checks = 0;
   always #50 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string n, input logic [15:0] e, s);
      total_checks++;
      if (e !== s) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task cyc(input int n); repeat (n) @(posedge clk); endtask
   task pin(input logic ia, ib); a <= ia ^ la; b <= ib ^ lb; endtask
   task strobe(input logic [1:0] k, input logic [5:0] p, input logic ex);
      kind <= k; pt <= p; stb <= 1;
      if (ex) q.push_back(p);
      cyc(4); stb <= 0; cyc(4);
   endtask
   task idle;
      for (int i = 0; i < 500 && inop !== 1'h1; i++) @(negedge clk);
      chk("in_operation", 1, inop);
      @(negedge clk);
      chk("shared", {15'h0, !sel}, sh);
      @(posedge clk);
      $display("test done, mismatches %0d", num_errors);
   endtask
   // Stop in mid-move: first pin pair, then second, then release
   task run(input logic a1, b1, a2, b2, input logic [15:0] e);
      strobe(`OP_STEP, ~cur, 1);
      pin(a1, b1); cyc(4); pin(a2, b2); cyc(4); pin(0, 0); idle;
      chk("decel_time", e, dt);
      chk("point", cur, cp);
   endtask
   always @(negedge clk) if (start === 1'h1) begin
      if (q.size() == 0) chk("unexpected start", 0, 1);
      else chk("target", q.pop_front(), tp);
   end
   motion_stop_control i_motion_stop_control (.i_clk_sys(clk), .i_reset_n(rst_n),
      .i_multifunction_input_a(a), .i_multifunction_input_b(b), .i_start_strobe_input(stb),
      .i_input_a_function_select(fa), .i_input_b_function_select(fb), .i_input_a_logic_select(la),
      .i_input_b_logic_select(lb), .i_shared_output_select(sel), .i_emergency_decel_time(et),
      .i_mode_decel_time(mt), .i_start_kind(kind), .i_point_select_inputs(pt), .i_motion_done(done),
      .i_motion_stopped(stopped), .o_motion_start(start), .o_motion_decel(decel), .o_decel_time(dt),
      .o_target_point(tp), .o_in_operation(inop), .o_shared_output(sh), .o_current_point_outputs(cp));
   motion_profile_model i_motion_profile_model (.i_clk_sys(clk), .i_reset_n(rst_n), .i_start(start),
      .i_decel(decel), .i_time(dt), .o_done(done), .o_stopped(stopped));
   initial begin
      {la, lb, sel} = r[2:0];
      {a, b} = {la, lb};
      cyc(20); rst_n <= 1; cyc(4);
      r = lfsr(r); cur = r[5:0];
      strobe(`OP_STEP, cur, 1); idle; chk("point", cur, cp);
      run(1, 0, 0, 0, et);
      run(0, 1, 0, 1, mt);
      run(1, 1, 1, 1, et);
      run(0, 1, 1, 1, 0);
      pin(1, 0); cyc(5); strobe(`OP_STEP, ~cur, 0); pin(0, 0); cyc(2);
      et <= 0; run(1, 0, 0, 0, 0);
      fb <= `FUNC_TEMP_STOP; r = lfsr(r);
      strobe(`OP_STEP, r[5:0], 1); pin(0, 1); cyc(30);
      @(negedge clk); chk("in_operation", 0, inop); chk("shared", {15'h0, !sel}, sh); @(posedge clk);
      q.push_back(r[5:0]); pin(0, 0); idle; cur = r[5:0]; chk("point", cur, cp);
      pin(0, 1); cyc(5); strobe(`OP_JOG, 6'h11, 0); strobe(`OP_HOMING, 6'h12, 0);
      strobe(`OP_STEP, ~cur, 1); pin(0, 0); cyc(5); idle; cur = ~cur; chk("point", cur, cp);
      strobe(`OP_JOG, 6'h05, 1); pin(0, 1); cyc(4); pin(0, 0); idle;
      strobe(`OP_HOMING, 6'h06, 1); pin(0, 1); cyc(4); pin(0, 0); idle;
      strobe(`OP_HOMING, 6'h06, 1); idle; cur = 6'h06; chk("point", cur, cp);
      strobe(`OP_STEP, ~cur, 1); pin(0, 1); cyc(30); pin(1, 1); cyc(4); pin(0, 0); idle;
      chk("point", cur, cp);
      finish_test;
   end
   initial begin
      #2000000;
      num_errors++;
      finish_test;
   end
endmodule // motion_stop_control_tb
